// File: lbdc_pkg.sv
// shared constants and types of the lamp brightness and dimming core
package lbdc_pkg;
	// brightness code
	localparam int CODE_W       = 5;
	localparam int CODE_MAX     = 31;
	localparam int CODE_SPAN    = 32;
	// quantizer threshold divisor and current target divisor
	localparam int QUANT_DIV    = 33;
	localparam int TARGET_DIV   = 160;
	// pulse dimming period in sync ticks and duty steps
	localparam int PD_TICKS     = 128;
	localparam int PD_TICK_W    = 7;
	localparam int PD_STEP      = 4;   // 3.125 % of 128 ticks
	localparam int PD_MIN_CODE  = 3;   // codes 0..3 share the floor duty
	localparam int PD_MIN_TICKS = 12;  // about 9 % of 128 ticks
	// clock and times
	localparam int CLK_HZ        = 10_000_000;
	localparam int LAMP_OUT_S    = 2;
	localparam int LAMP_OUT_CYC  = LAMP_OUT_S * CLK_HZ;
	localparam int SYNC_MIN_HZ   = 32_000;
	localparam int SYNC_MAX_HZ   = 100_000;
	localparam int SYNC_LOSS_CYC =
		2 * ((CLK_HZ + SYNC_MIN_HZ - 1) / SYNC_MIN_HZ);
	localparam int INT_OSC_HZ    = 50_000;
	localparam int INT_TICK_CYC  = CLK_HZ / INT_OSC_HZ;
	// register map
	localparam int ADDR_W        = 4;
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int CTRL_SHDN_BIT  = 0;
	localparam int CTRL_BRT_LSB   = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// static level seen on the mode pin
	typedef enum logic [1:0] {
		LBDC_MODE_GND = 2'h0,
		LBDC_MODE_REF = 2'h1,
		LBDC_MODE_VCC = 2'h2
	} lbdc_mode_t;
	// run state, one-hot
	typedef enum logic [2:0] {
		LBDC_ST_SHDN  = 3'h1,
		LBDC_ST_RUN   = 3'h2,
		LBDC_ST_FAULT = 3'h4
	} lbdc_state_t;
	// status word layout
	typedef struct packed {
		logic [15:0] zero;
		logic        sync_locked;
		logic        uvlo;
		logic        short_fault;
		logic        lamp_out_fault;
		logic        shutdown;
		logic [2:0]  state;
		logic [2:0]  zero2;
		logic [CODE_W-1:0] code;
	} lbdc_status_t;
endpackage : lbdc_pkg

// File: lbdc_quant.sv
// hysteretic five-bit quantizer of the analog brightness control
`timescale 1ns/1ns
module lbdc_quant #(
	parameter int LVL_W = 12
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rstn,
	input  wire logic                      clk_en,
	input  wire logic                      neg_scale,
	input  wire logic [LVL_W-1:0]          ctl_level,
	input  wire logic [LVL_W-1:0]          ref_level,
	output logic [lbdc_pkg::CODE_W-1:0]    code_q
);
	localparam int PW = LVL_W + 6;
	logic [PW-1:0] ctl_x33;
	logic [PW-1:0] up_thr;
	logic [PW-1:0] dn_thr;
	logic [5:0]    up_mul;
	logic [5:0]    dn_mul;
	logic [lbdc_pkg::CODE_W-1:0] code_d;

	// threshold multipliers for the current code
	always_comb begin
		if (neg_scale) begin
			up_mul = 6'(lbdc_pkg::QUANT_DIV) - 6'(code_q);
			dn_mul = 6'(lbdc_pkg::CODE_MAX) - 6'(code_q);
		end else begin
			up_mul = 6'(code_q) + 6'h02;
			dn_mul = 6'(code_q);
		end
		ctl_x33 = PW'(ctl_level) * PW'(lbdc_pkg::QUANT_DIV);
		up_thr  = PW'(ref_level) * PW'(up_mul);
		dn_thr  = PW'(ref_level) * PW'(dn_mul);
	end

	// one step per clock, two-step gap between thresholds
	always_comb begin
		code_d = code_q;
		if (!neg_scale) begin
			if (code_q != 5'h1F && ctl_x33 >= up_thr)
				code_d = code_q + 5'h01;
			else if (code_q != 5'h00 && ctl_x33 < dn_thr)
				code_d = code_q - 5'h01;
		end else begin
			if (code_q != 5'h00 && ctl_x33 >= up_thr)
				code_d = code_q - 5'h01;
			else if (code_q != 5'h1F && ctl_x33 < dn_thr)
				code_d = code_q + 5'h01;
		end
	end

	// code register
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			code_q <= '0;
		else if (clk_en)
			code_q <= code_d;
	end
endmodule : lbdc_quant

// File: lbdc_core.sv
// brightness code, current target, pulse dimming and protection core
//
// What this block does
// - one 5-bit code from selected interface sets current and duty
// - code zero means lowest current level, code 31 means highest
// - target equals ref times n/160 plus setpoint times (32-n)/160
// - duty rises 3.125 % per step to 100 %; codes 0..3 give 9 %
// - setpoint at rail: duty fixed 100 %, setpoint taken as zero
// - setpoint equal to reference: target stays at its maximum
// - with both controls, current is regulated only during on time
// - positive scale counts up with input, negative scale counts down
// - rising thresholds (n+2)/33 positive, (33-n)/33 negative
// - falling thresholds n/33 positive, (31-n)/33 negative
// - one code step of hysteresis stops toggling between codes
// - with external sync one dimming period spans 128 sync pulses
// - mode pin level selects interface and its edges give sync
// - rail selects serial, reference negative scale, ground positive
// - reset clears code, target, faults and serial registers
// - undervoltage holds high and low bridge drivers off
// - shutdown stops all but register retention and serial access
// - entering shutdown clears lamp-out and short-circuit faults
// - lamp-out timer starts when sense peak drops below 150 mV
// - peak low for more than 2 s latches lamp-out, bridge off
`timescale 1ns/1ns
module lbdc_core #(
	parameter int LVL_W        = 12,
	parameter int LAMP_OUT_CYC = lbdc_pkg::LAMP_OUT_CYC,
	parameter int SYNC_LOSS    = lbdc_pkg::SYNC_LOSS_CYC,
	parameter int INT_TICK     = lbdc_pkg::INT_TICK_CYC
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	input  wire logic                   clk_en,
	// register port
	input  wire logic [lbdc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [31:0]                 reg_rdata,
	// mode pin: static level and ac-coupled sync edges
	input  wire lbdc_pkg::lbdc_mode_t   mode_level,
	input  wire logic                   mode_sync,
	// analog levels as sampled values
	input  wire logic [LVL_W-1:0]       brightness_control_input,
	input  wire logic [LVL_W-1:0]       brightness_reference_input,
	input  wire logic [LVL_W-1:0]       min_current_setpoint_pin,
	input  wire logic                   min_setpoint_at_rail,
	// protection inputs
	input  wire logic                   shutdown_suspend_input,
	input  wire logic                   vcc_below_uvlo,
	input  wire logic                   sense_peak_low,
	input  wire logic                   short_detect,
	// outputs
	output logic [lbdc_pkg::CODE_W-1:0] brightness_code,
	output logic [LVL_W-1:0]            current_target_q,
	output logic                        pulse_dimming,
	output logic                        current_reg_en,
	output logic                        bridge_high_en,
	output logic                        bridge_low_en,
	output logic                        lamp_out_fault
);
	localparam int TW  = $clog2(LAMP_OUT_CYC + 1);
	localparam int SW  = $clog2(SYNC_LOSS + 1);
	localparam int IW  = $clog2(INT_TICK + 1);
	localparam int MW  = LVL_W + 6;

	// refuse settings the counters and arithmetic cannot serve
	if (LVL_W < 4 || LVL_W > 24 || LAMP_OUT_CYC < 1 || SYNC_LOSS < 2
		|| INT_TICK < 2 || INT_TICK >= SYNC_LOSS) begin : g_bad_param
		$error("lbdc_core: unsupported parameter values");
	end

	lbdc_pkg::lbdc_state_t state_q;
	lbdc_pkg::lbdc_state_t state_d;
	lbdc_pkg::lbdc_status_t status_w;
	logic [31:0]            ctrl_q;
	logic [31:0]            rdata_d;
	logic [lbdc_pkg::CODE_W-1:0] quant_code;
	logic [lbdc_pkg::CODE_W-1:0] code_sel;
	logic [lbdc_pkg::CODE_W-1:0] code_q;
	logic                   shdn_req;
	logic                   shdn_q;
	logic                   lamp_fault_q;
	logic                   short_fault_q;
	logic [TW-1:0]          lamp_cnt_q;
	logic                   sync_prev_q;
	logic                   sync_edge;
	logic [SW-1:0]          sync_age_q;
	logic                   sync_locked;
	logic [IW-1:0]          int_cnt_q;
	logic                   int_tick;
	logic                   pd_tick;
	logic [lbdc_pkg::PD_TICK_W-1:0] pd_cnt_q;
	logic [lbdc_pkg::PD_TICK_W:0]   duty_ticks;
	logic                   pd_on_d;
	logic                   pd_on_q;
	logic [LVL_W-1:0]       setpoint_eff;
	logic [MW-1:0]          target_sum;
	logic [LVL_W-1:0]       target_d;
	logic                   drive_ok;

	// duty in sync ticks for a code, floor shared by the lowest codes
	function automatic logic [lbdc_pkg::PD_TICK_W:0] duty_of(
		input logic [lbdc_pkg::CODE_W-1:0] n
	);
		logic [lbdc_pkg::PD_TICK_W:0] t;
		t = (8'(n) + 8'h01) * 8'(lbdc_pkg::PD_STEP);
		if (n <= 5'(lbdc_pkg::PD_MIN_CODE))
			t = 8'(lbdc_pkg::PD_MIN_TICKS);
		return t;
	endfunction : duty_of

	// analog quantizer; negative scale when mode pin sits at reference
	lbdc_quant #(
		.LVL_W     (LVL_W)
	) u_quant (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.clk_en    (clk_en),
		.neg_scale (mode_level == lbdc_pkg::LBDC_MODE_REF),
		.ctl_level (brightness_control_input),
		.ref_level (brightness_reference_input),
		.code_q    (quant_code)
	);

	// control register: shutdown bit and serial brightness code
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			ctrl_q <= lbdc_pkg::CTRL_RESET;
		else if (clk_en && reg_wr && reg_addr == lbdc_pkg::REG_CTRL)
			ctrl_q <= reg_wdata;
	end

	// status word
	always_comb begin
		status_w                = '0;
		status_w.code           = code_q;
		status_w.state          = state_q;
		status_w.shutdown       = shdn_q;
		status_w.lamp_out_fault = lamp_fault_q;
		status_w.short_fault    = short_fault_q;
		status_w.uvlo           = vcc_below_uvlo;
		status_w.sync_locked    = sync_locked;
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			lbdc_pkg::REG_CTRL: begin
				rdata_d = ctrl_q;
			end
			lbdc_pkg::REG_STATUS: begin
				rdata_d = status_w;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			reg_rdata <= '0;
		else if (clk_en)
			reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
	end

	// code source follows the mode pin level
	always_comb begin
		if (mode_level == lbdc_pkg::LBDC_MODE_VCC)
			code_sel = ctrl_q[lbdc_pkg::CTRL_BRT_LSB +: lbdc_pkg::CODE_W];
		else
			code_sel = quant_code;
	end

	// active code; held while shut down so settings are retained
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			code_q <= '0;
		else if (clk_en && state_q != lbdc_pkg::LBDC_ST_SHDN)
			code_q <= code_sel;
	end

	// shutdown request from register or pin
	assign shdn_req = ctrl_q[lbdc_pkg::CTRL_SHDN_BIT]
		| shutdown_suspend_input;

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			shdn_q <= 1'b0;
		else if (clk_en)
			shdn_q <= shdn_req;
	end

	// run state
	always_comb begin
		case (state_q)
			lbdc_pkg::LBDC_ST_RUN: begin
				if (shdn_req)
					state_d = lbdc_pkg::LBDC_ST_SHDN;
				else if (lamp_fault_q || short_fault_q)
					state_d = lbdc_pkg::LBDC_ST_FAULT;
				else
					state_d = lbdc_pkg::LBDC_ST_RUN;
			end
			lbdc_pkg::LBDC_ST_FAULT: begin
				if (shdn_req)
					state_d = lbdc_pkg::LBDC_ST_SHDN;
				else
					state_d = lbdc_pkg::LBDC_ST_FAULT;
			end
			lbdc_pkg::LBDC_ST_SHDN: begin
				if (!shdn_req)
					state_d = lbdc_pkg::LBDC_ST_RUN;
				else
					state_d = lbdc_pkg::LBDC_ST_SHDN;
			end
			default: begin
				state_d = lbdc_pkg::LBDC_ST_SHDN;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			state_q <= lbdc_pkg::LBDC_ST_RUN;
		else if (clk_en)
			state_q <= state_d;
	end

	// lamp-out timer: counts while peak low, cleared on recovery
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			lamp_cnt_q <= '0;
		else if (clk_en) begin
			if (state_q != lbdc_pkg::LBDC_ST_RUN || !sense_peak_low)
				lamp_cnt_q <= '0;
			else if (lamp_cnt_q != TW'(LAMP_OUT_CYC))
				lamp_cnt_q <= lamp_cnt_q + TW'(1);
		end
	end

	// lamp-out latch; shutdown clears it, detection is off meanwhile
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			lamp_fault_q <= 1'b0;
		else if (clk_en) begin
			if (state_q == lbdc_pkg::LBDC_ST_RUN && sense_peak_low
				&& lamp_cnt_q == TW'(LAMP_OUT_CYC))
				lamp_fault_q <= 1'b1;
			else if (state_q == lbdc_pkg::LBDC_ST_SHDN)
				lamp_fault_q <= 1'b0;
		end
	end

	// short-circuit latch, cleared in shutdown
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			short_fault_q <= 1'b0;
		else if (clk_en) begin
			if (state_q == lbdc_pkg::LBDC_ST_RUN && short_detect)
				short_fault_q <= 1'b1;
			else if (state_q == lbdc_pkg::LBDC_ST_SHDN)
				short_fault_q <= 1'b0;
		end
	end

	// sync edge on mode pin and its age since the last edge
	assign sync_edge   = mode_sync & ~sync_prev_q;
	assign sync_locked = sync_age_q != SW'(SYNC_LOSS);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sync_prev_q <= 1'b0;
			sync_age_q  <= SW'(SYNC_LOSS);
		end else if (clk_en) begin
			sync_prev_q <= mode_sync;
			if (sync_edge)
				sync_age_q <= '0;
			else if (sync_locked)
				sync_age_q <= sync_age_q + SW'(1);
		end
	end

	// internal oscillator tick used when no sync is applied
	assign int_tick = int_cnt_q == IW'(INT_TICK - 1);

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			int_cnt_q <= '0;
		else if (clk_en)
			int_cnt_q <= int_tick ? '0 : int_cnt_q + IW'(1);
	end

	assign pd_tick = sync_locked ? sync_edge : int_tick;

	// dimming period counter, 128 ticks per period
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			pd_cnt_q <= '0;
		else if (clk_en) begin
			if (state_q != lbdc_pkg::LBDC_ST_RUN)
				pd_cnt_q <= '0;
			else if (pd_tick)
				pd_cnt_q <= pd_cnt_q + 7'h01;
		end
	end

	// duty compare; setpoint at rail forces full duty
	always_comb begin
		duty_ticks = duty_of(code_q);
		if (min_setpoint_at_rail)
			duty_ticks = 8'(lbdc_pkg::PD_TICKS);
		pd_on_d = {1'b0, pd_cnt_q} < duty_ticks;
	end

	assign drive_ok = state_q == lbdc_pkg::LBDC_ST_RUN
		&& !vcc_below_uvlo;

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			pd_on_q <= 1'b0;
		else if (clk_en)
			pd_on_q <= drive_ok && pd_on_d;
	end

	// current target; setpoint equal to reference gives full scale
	always_comb begin
		setpoint_eff = min_setpoint_at_rail ? '0
			: min_current_setpoint_pin;
		target_sum = MW'(brightness_reference_input) * MW'(code_q)
			+ MW'(setpoint_eff)
			* MW'(6'(lbdc_pkg::CODE_SPAN) - 6'(code_q));
		target_d = LVL_W'(target_sum / MW'(lbdc_pkg::TARGET_DIV));
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			current_target_q <= '0;
		else if (clk_en && state_q != lbdc_pkg::LBDC_ST_SHDN)
			current_target_q <= target_d;
	end

	// outputs; undervoltage and faults keep both drivers off
	assign brightness_code = code_q;
	assign pulse_dimming   = pd_on_q;
	assign current_reg_en  = pd_on_q;
	assign bridge_high_en  = pd_on_q & ~vcc_below_uvlo;
	assign bridge_low_en   = pd_on_q & ~vcc_below_uvlo;
	assign lamp_out_fault  = lamp_fault_q;
endmodule : lbdc_core

// File: lbdc_core_chk.sv
// assertion checker for the lamp brightness and dimming core
`timescale 1ns/1ns
module lbdc_core_chk #(
	parameter int LAMP_OUT_CYC = 50
) (
	input wire logic                          clk_sys,
	input wire logic                          rstn,
	input wire logic [lbdc_pkg::ADDR_W-1:0]   reg_addr,
	input wire logic [31:0]                   reg_wdata,
	input wire logic                          reg_wr,
	input wire logic                          reg_rd,
	input wire logic [31:0]                   reg_rdata,
	input wire logic                          min_setpoint_at_rail,
	input wire logic                          shutdown_suspend_input,
	input wire logic                          vcc_below_uvlo,
	input wire logic                          sense_peak_low,
	input wire logic                          short_detect,
	input wire logic                          pulse_dimming,
	input wire logic                          current_reg_en,
	input wire logic                          bridge_high_en,
	input wire logic                          bridge_low_en,
	input wire logic                          lamp_out_fault
);
	localparam int LW = $clog2(LAMP_OUT_CYC + 2);
	logic [LW-1:0] lo_cnt_q;
	logic [3:0] rail_cnt_q;
	logic       ctrl_sd_q;
	logic       dirty_q;
	logic       sd_any;
	assign sd_any = shutdown_suspend_input | ctrl_sd_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// run of low sense-peak cycles, saturating
	always_ff @(posedge clk_sys) begin
		if (!rstn || !sense_peak_low) lo_cnt_q <= '0;
		else if (lo_cnt_q != '1) lo_cnt_q <= lo_cnt_q + LW'(1);
	end
	// shadow of the shutdown bit
	always_ff @(posedge clk_sys) begin
		if (!rstn) ctrl_sd_q <= 1'b0;
		else if (reg_wr && reg_addr == lbdc_pkg::REG_CTRL)
			ctrl_sd_q <= reg_wdata[0];
	end
	// some fault may be latched until the next shutdown
	always_ff @(posedge clk_sys) begin
		if (!rstn || sd_any) dirty_q <= 1'b0;
		else if (short_detect || lamp_out_fault) dirty_q <= 1'b1;
	end
	// quiet cycles with the setpoint tied to the rail
	always_ff @(posedge clk_sys) begin
		if (!rstn || !min_setpoint_at_rail || sd_any || dirty_q
			|| short_detect || sense_peak_low || vcc_below_uvlo)
			rail_cnt_q <= 4'h0;
		else if (rail_cnt_q != 4'hF) rail_cnt_q <= rail_cnt_q + 4'h1;
	end
	a_uvlo_bridge_off: assert property (
		vcc_below_uvlo |-> !bridge_high_en && !bridge_low_en)
		else $error("bridge driven during undervoltage");
	a_bridge_gate: assert property (
		bridge_low_en == (pulse_dimming && !vcc_below_uvlo))
		else $error("low bridge enable not tied to dimming");
	a_reg_on_time: assert property (
		current_reg_en == pulse_dimming)
		else $error("current regulation outside on interval");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside read answer cycle");
	a_fault_rise: assert property (
		$rose(lamp_out_fault) |-> lo_cnt_q >= LW'(LAMP_OUT_CYC))
		else $error("lamp fault before timeout");
	a_fault_stops: assert property (
		lamp_out_fault [*4] |-> !pulse_dimming && !bridge_high_en)
		else $error("bridge still driven after lamp fault");
	a_fault_holds: assert property (
		lamp_out_fault && !sd_any |=> lamp_out_fault)
		else $error("lamp fault dropped without shutdown");
	a_shdn_clears: assert property (
		shutdown_suspend_input [*3] |-> !lamp_out_fault)
		else $error("lamp fault kept in shutdown");
	a_rail_full: assert property (
		rail_cnt_q == 4'hF |-> pulse_dimming)
		else $error("dimming off with setpoint at rail");
endmodule : lbdc_core_chk

bind lbdc_core lbdc_core_chk #(.LAMP_OUT_CYC(LAMP_OUT_CYC)) u_chk (
	.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .min_setpoint_at_rail, .shutdown_suspend_input,
	.vcc_below_uvlo, .sense_peak_low, .short_detect, .pulse_dimming,
	.current_reg_en, .bridge_high_en, .bridge_low_en, .lamp_out_fault);

// File: lbdc_partner.sv
// model of the sync source and the lamp sense path
`timescale 1ns/1ns
module lbdc_partner #(
	parameter int HALF = 100
) (
	input  wire logic clk_sys,
	input  wire logic sync_en,
	input  wire logic lamp_open,
	output logic      mode_sync,
	output logic      sense_peak_low
);
	int cnt;
	// 50 kHz square wave, stands low when the source is off
	always_ff @(posedge clk_sys) begin
		if (!sync_en) begin
			cnt <= 0;
			mode_sync <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			mode_sync <= !mode_sync;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// an open lamp keeps the sense peak under threshold
	always_ff @(posedge clk_sys) sense_peak_low <= lamp_open;
endmodule : lbdc_partner

// File: test_lbdc_core.sv
// self-checking bench of the lamp brightness and dimming core
`timescale 1ns/1ns
`define CHK(s, e, a) begin checks_done++; if ((a) !== (e)) begin \
	num_errors++; $display("unexpected %s exp %0h got %0h", s, e, a); end end
module test_lbdc_core;
	logic        clk_sys, rstn, clk_en, reg_wr, reg_rd, mode_sync, sync_en;
	logic        min_setpoint_at_rail, shutdown_suspend_input, lamp_open;
	logic        vcc_below_uvlo, sense_peak_low, short_detect, pulse_dimming;
	logic        current_reg_en, bridge_high_en, bridge_low_en, lamp_out_fault;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [11:0] brightness_control_input, brightness_reference_input;
	logic [11:0] min_current_setpoint_pin, current_target_q;
	logic [4:0]  brightness_code;
	lbdc_pkg::lbdc_mode_t mode_level;
	int          num_errors, checks_done, k, e;
	int          tn[6] = '{0, 3, 4, 31, 17, 9};
	int          ts[6] = '{1200, 1200, 1200, 1200, 3300, 1200};
	int          qc[8] = '{0, 1050, 950, 850, 3300, 1050, 0, 3300};
	int          qe[8] = '{0, 9, 9, 8, 31, 10, 31, 0};
	lbdc_partner #(.HALF(100)) u_far (.clk_sys, .sync_en, .lamp_open,
		.mode_sync, .sense_peak_low);
	lbdc_core #(.LVL_W(12), .LAMP_OUT_CYC(50), .INT_TICK(4)) u_dut (
		.clk_sys, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .mode_level, .mode_sync, .brightness_control_input,
		.brightness_reference_input, .min_current_setpoint_pin,
		.min_setpoint_at_rail, .shutdown_suspend_input, .vcc_below_uvlo,
		.sense_peak_low, .short_detect, .brightness_code, .current_target_q,
		.pulse_dimming, .current_reg_en, .bridge_high_en, .bridge_low_en,
		.lamp_out_fault);
	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = !clk_sys;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		rv = reg_rdata;
	endtask : rd
	// on cycles over exactly one dimming period of t clocks per tick
	task automatic meas(input int t, input int d);
		int h;
		h = 0;
		repeat (128 * t) begin
			@(posedge clk_sys);
			h += int'(pulse_dimming);
		end
		`CHK("duty cycles", d * t, h)
	endtask : meas
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	// watchdog cuts a hang short
	initial begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		final_report();
	end
	// main sequence
	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		mode_level = lbdc_pkg::LBDC_MODE_VCC;
		brightness_control_input = 12'h000;
		brightness_reference_input = 12'hCE4;
		min_current_setpoint_pin = 12'h4B0;
		min_setpoint_at_rail = 1'b0;
		shutdown_suspend_input = 1'b0;
		vcc_below_uvlo = 1'b0;
		short_detect = 1'b0;
		sync_en = 1'b0;
		lamp_open = 1'b0;
		cyc(20);
		rstn <= 1'b1;
		cyc(1);
		`CHK("code", 5'h00, brightness_code)
		`CHK("target", 12'h000, current_target_q)
		`CHK("fault", 1'b0, lamp_out_fault)
		rd(lbdc_pkg::REG_CTRL);
		`CHK("ctrl", lbdc_pkg::CTRL_RESET, rv)
		rd(4'h8);
		`CHK("unmapped", 32'h0000_0000, rv)
		done("reset");
		// serial codes against current target and duty
		for (int i = 0; i < 6; i++) begin
			min_current_setpoint_pin <= 12'(ts[i]);
			min_setpoint_at_rail <= (i == 5);
			wr(lbdc_pkg::REG_CTRL, 32'(tn[i]) << 8);
			cyc(520);
			e = (i == 5) ? 0 : ts[i];
			e = (3300 * tn[i] + e * (32 - tn[i])) / 160;
			`CHK("code", 5'(tn[i]), brightness_code)
			`CHK("target", 12'(e), current_target_q)
			e = (i == 5) ? 128 : (tn[i] <= 3) ? 12 : (tn[i] + 1) * 4;
			meas(4, e);
		end
		done("serial");
		// analog quantizer on both scales
		min_setpoint_at_rail <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			mode_level <= (i < 6) ? lbdc_pkg::LBDC_MODE_GND
				: lbdc_pkg::LBDC_MODE_REF;
			brightness_control_input <= 12'(qc[i]);
			cyc(40);
			`CHK("quant", 5'(qe[i]), brightness_code)
		end
		done("quantizer");
		// external sync sets the period, internal tick without it
		mode_level <= lbdc_pkg::LBDC_MODE_VCC;
		wr(lbdc_pkg::REG_CTRL, 32'h0000_0F00);
		sync_en <= 1'b1;
		cyc(1000);
		meas(200, 64);
		sync_en <= 1'b0;
		cyc(1500);
		meas(4, 64);
		done("sync");
		// undervoltage stops dimming and both bridge drivers
		min_setpoint_at_rail <= 1'b1;
		cyc(600);
		`CHK("dimming", 1'b1, pulse_dimming)
		vcc_below_uvlo <= 1'b1;
		cyc(2);
		`CHK("dimming", 1'b0, pulse_dimming)
		`CHK("bridge high", 1'b0, bridge_high_en)
		`CHK("bridge low", 1'b0, bridge_low_en)
		vcc_below_uvlo <= 1'b0;
		cyc(2);
		`CHK("bridge high", 1'b1, bridge_high_en)
		done("uvlo");
		// lamp out: a short dropout first, then a lasting one
		lamp_open <= 1'b1;
		cyc(40);
		lamp_open <= 1'b0;
		cyc(5);
		`CHK("fault", 1'b0, lamp_out_fault)
		lamp_open <= 1'b1;
		k = 0;
		while (lamp_out_fault !== 1'b1 && k < 70) begin
			cyc(1);
			k++;
		end
		`CHK("lamp delay", 1'b1, k >= 51 && k <= 56)
		cyc(4);
		`CHK("dimming", 1'b0, pulse_dimming)
		`CHK("bridge high", 1'b0, bridge_high_en)
		shutdown_suspend_input <= 1'b1;
		lamp_open <= 1'b0;
		cyc(4);
		`CHK("fault", 1'b0, lamp_out_fault)
		rd(lbdc_pkg::REG_STATUS);
		`CHK("state", 3'h1, rv[10:8])
		`CHK("kept code", 5'h0F, rv[4:0])
		shutdown_suspend_input <= 1'b0;
		done("lamp out");
		// short fault cleared through the shutdown bit
		cyc(4);
		short_detect <= 1'b1;
		cyc(1);
		short_detect <= 1'b0;
		rd(lbdc_pkg::REG_STATUS);
		`CHK("short", 1'b1, rv[13])
		wr(lbdc_pkg::REG_CTRL, 32'h0000_0F01);
		cyc(4);
		`CHK("dimming", 1'b0, pulse_dimming)
		wr(lbdc_pkg::REG_STATUS, 32'hFFFF_FFFF);
		rd(lbdc_pkg::REG_STATUS);
		`CHK("short", 1'b0, rv[13])
		`CHK("state", 3'h1, rv[10:8])
		rd(lbdc_pkg::REG_CTRL);
		`CHK("ctrl", 32'h0000_0F01, rv)
		wr(lbdc_pkg::REG_CTRL, 32'h0000_0F00);
		cyc(20);
		`CHK("dimming", 1'b1, pulse_dimming)
		done("shutdown");
		// clock enable low freezes state and ignores the bus
		clk_en <= 1'b0;
		wr(lbdc_pkg::REG_CTRL, 32'h0000_1F00);
		cyc(4);
		`CHK("frozen dimming", 1'b1, pulse_dimming)
		clk_en <= 1'b1;
		rd(lbdc_pkg::REG_CTRL);
		`CHK("frozen ctrl", 32'h0000_0F00, rv)
		`CHK("frozen code", 5'h0F, brightness_code)
		done("clock enable");
		final_report();
	end
endmodule : test_lbdc_core
